/* muxed_video_input_port_map.svh */
// constants of the multiplexed video input port
`ifndef MUXED_VIDEO_INPUT_PORT_MAP_SVH
`define MUXED_VIDEO_INPUT_PORT_MAP_SVH

`define FMT_RGB12_A 3'h0
`define FMT_RGB12_B 3'h1
`define FMT_RGB565 3'h2
`define FMT_RGB555 3'h3
`define FMT_YCRCB 3'h4

`define BUS_WIDTH 12
`define PIXEL_WIDTH 24

`define TRS_FIRST 8'hFF
`define TRS_ZERO 8'h00
`define TRS_FIELD_BIT 6
`define TRS_VBLANK_BIT 5
`define TRS_EAV_BIT 4

`define BLANK_LUMA 8'h10
`define BLANK_CHROMA 8'h80

`define CORE_CLK_MHZ 10
`define PIXEL_RATE_MAX_MHZ 165

`endif

/* muxed_video_input_port_pkg.sv */
// types shared by the multiplexed video input port
package muxed_video_input_port_pkg;

  typedef logic [2:0] format_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] mid;
    logic [7:0] lo;
  } pixel_t;

  typedef struct packed {
    logic field;
    logic vblank;
    logic eav;
  } timing_status_t;

endpackage : muxed_video_input_port_pkg

/* two_flop_sync.sv */
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module two_flop_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("two_flop_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : two_flop_sync

/* pixel_decoder.sv */
// decodes a first/second word pair into one pixel per the selected format
`timescale 1ns/1ps
`include "muxed_video_input_port_map.svh"
module pixel_decoder
  import muxed_video_input_port_pkg::*;
(
  input wire logic [`BUS_WIDTH-1:0] first_word_i,
  input wire logic [`BUS_WIDTH-1:0] second_word_i,
  input wire format_t input_format_select_i,
  output pixel_t pixel_o,
  output logic format_error_o
);

  wire logic [`BUS_WIDTH-1:0] a = first_word_i;
  wire logic [`BUS_WIDTH-1:0] b = second_word_i;

  // full-width 24-bit colour schemes
  wire pixel_t pix_a = '{hi: b[11:4], mid: {b[3:0], a[11:8]}, lo: a[7:0]};
  wire pixel_t pix_b = '{hi: {b[11:7], b[3:1]}, mid: {b[6:4], a[11:9], b[0], a[3]},
                         lo: {a[8:4], a[2:0]}};
  // 8-line schemes, low bits filled with zero
  wire pixel_t pix_565 = '{hi: {b[11:7], 3'h0}, mid: {b[6:4], a[11:9], 2'h0},
                           lo: {a[8:4], 3'h0}};
  wire pixel_t pix_555 = '{hi: {b[10:6], 3'h0}, mid: {b[5:4], a[11:9], 3'h0},
                           lo: {a[8:4], 3'h0}};
  wire pixel_t pix_ycc = '{hi: b[7:0], mid: a[7:0], lo: 8'h00};

  wire logic sel_a = (input_format_select_i == `FMT_RGB12_A);
  wire logic sel_b = (input_format_select_i == `FMT_RGB12_B);
  wire logic sel_565 = (input_format_select_i == `FMT_RGB565);
  wire logic sel_555 = (input_format_select_i == `FMT_RGB555);
  wire logic sel_ycc = (input_format_select_i == `FMT_YCRCB);

  // format select picks one of five decodings
  assign pixel_o = sel_a ? pix_a :
                   sel_b ? pix_b :
                   sel_565 ? pix_565 :
                   sel_555 ? pix_555 :
                   sel_ycc ? pix_ycc : '0;
  assign format_error_o = !(sel_a || sel_b || sel_565 || sel_555 || sel_ycc);

endmodule : pixel_decoder

/* muxed_video_input_port.sv */
// multiplexed video input port: link clock sampling, word pairing, pixel decode, embedded sync
`timescale 1ns/1ps
`include "muxed_video_input_port_map.svh"
module muxed_video_input_port
  import muxed_video_input_port_pkg::*;
#(
  parameter int BUS_WIDTH = `BUS_WIDTH,
  parameter int INDEX_WIDTH = 12
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic pixel_clock_pair_p_i,
  input wire logic pixel_clock_pair_n_i,
  input wire logic [BUS_WIDTH-1:0] data_i,
  input wire logic line_sync_i,
  input wire logic clock_rate_2x_i,
  input wire logic capture_edge_polarity_i,
  input wire logic single_ended_clock_i,
  input wire format_t input_format_select_i,
  output pixel_t pixel_o,
  output logic pixel_valid_o,
  output logic [INDEX_WIDTH-1:0] pixel_index_o,
  output logic line_start_o,
  output logic chroma_phase_flag_o,
  output logic embedded_code_o,
  output timing_status_t timing_status_o,
  output logic format_error_o,
  output logic rgb_format_o
);

  initial
  begin
    if (BUS_WIDTH != `BUS_WIDTH)
    begin
      $error("muxed_video_input_port: BUS_WIDTH must equal the 12-line bus");
    end
    if (INDEX_WIDTH < 1 || INDEX_WIDTH > 16)
    begin
      $error("muxed_video_input_port: INDEX_WIDTH out of range");
    end
  end

  typedef enum logic [1:0] {
    TRS_HUNT,
    TRS_GOT_FF00
  } trs_state_t;

  // pin inputs pass two flip-flops before use
  logic clk_p_s;
  logic clk_n_s;
  logic line_sync_s;
  logic [BUS_WIDTH-1:0] data_s;

  two_flop_sync #(
    .WIDTH(BUS_WIDTH + 3)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({pixel_clock_pair_p_i, pixel_clock_pair_n_i, line_sync_i, data_i}),
    .sync_o({clk_p_s, clk_n_s, line_sync_s, data_s})
  );

  // differential clock level: held while both lines agree
  logic clk_level_q;
  logic line_sync_q;
  wire logic pair_valid = single_ended_clock_i || (clk_p_s != clk_n_s);
  wire logic clk_level_d = pair_valid ? clk_p_s : clk_level_q;

  // rising means positive line up and complementary line down
  wire logic rise_ev = clk_level_d && !clk_level_q;
  wire logic fall_ev = !clk_level_d && clk_level_q;
  wire logic sel_edge_ev = capture_edge_polarity_i ? fall_ev : rise_ev;

  // 2x clock uses one edge, 1x clock uses both
  wire logic word_strobe = clock_rate_2x_i ? sel_edge_ev : (rise_ev || fall_ev);

  wire logic sync_lead = line_sync_s && !line_sync_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clk_level_q <= 1'b0;
      line_sync_q <= 1'b0;
    end
    else
    begin
      clk_level_q <= clk_level_d;
      line_sync_q <= line_sync_s;
    end
  end

  // sync alignment: the word after the leading edge is a first word
  logic sync_pending_q;
  logic second_next_q;
  logic [BUS_WIDTH-1:0] first_word_q;

  // a leading edge in the capture cycle keeps the flag set
  wire logic sync_pending_d = sync_lead ? 1'b1 : (word_strobe ? 1'b0 : sync_pending_q);
  wire logic take_first = word_strobe && (sync_pending_q || !second_next_q);
  wire logic take_second = word_strobe && !take_first;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_pending_q <= 1'b0;
      second_next_q <= 1'b0;
      first_word_q <= '0;
    end
    else
    begin
      sync_pending_q <= sync_pending_d;
      if (take_first)
      begin
        first_word_q <= data_s;
        second_next_q <= 1'b1;
      end
      else if (take_second)
      begin
        second_next_q <= 1'b0;
      end
    end
  end

  // pair decode: first word held, second word live
  pixel_t pix_dec;
  logic fmt_err;

  pixel_decoder u_decoder (
    .first_word_i(first_word_q),
    .second_word_i(data_s),
    .input_format_select_i(input_format_select_i),
    .pixel_o(pix_dec),
    .format_error_o(fmt_err)
  );

  // YCrCb chroma phase: 0 on a Cb pixel, 1 on a Cr pixel
  wire logic ycc_mode = (input_format_select_i == `FMT_YCRCB);
  logic chroma_phase_q;
  wire logic [7:0] a_byte = first_word_q[7:0];
  wire logic [7:0] b_byte = data_s[7:0];

  // embedded code hunt, aligned to Cb slots
  trs_state_t trs_q;
  trs_state_t trs_d;
  wire logic code_head = ycc_mode && !chroma_phase_q && (a_byte == `TRS_FIRST) && (b_byte == `TRS_ZERO);
  wire logic code_tail = ycc_mode && (trs_q == TRS_GOT_FF00) && (a_byte == `TRS_ZERO);
  wire logic code_done = take_second && code_tail;

  always_comb
  begin
    trs_d = trs_q;
    if (!ycc_mode)
    begin
      trs_d = TRS_HUNT;
    end
    else if (take_second)
    begin
      unique case (trs_q)
        TRS_HUNT: trs_d = code_head ? TRS_GOT_FF00 : TRS_HUNT;
        TRS_GOT_FF00: trs_d = TRS_HUNT;
      endcase
    end
  end

  // after a status byte the next pixel is a Cb pixel again
  wire logic chroma_phase_d = sync_lead ? 1'b0 :
                              code_done ? 1'b0 :
                              take_second ? !chroma_phase_q : chroma_phase_q;

  // status bits 6, 5, 4 only; the rest are ignored
  wire timing_status_t status_d = '{field: b_byte[`TRS_FIELD_BIT],
                                    vblank: b_byte[`TRS_VBLANK_BIT],
                                    eav: b_byte[`TRS_EAV_BIT]};

  // pixel index wraps at INDEX_WIDTH bits; no limit on line length
  wire logic [INDEX_WIDTH-1:0] index_next = pixel_index_o + INDEX_WIDTH'(1);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trs_q <= TRS_HUNT;
      chroma_phase_q <= 1'b0;
    end
    else
    begin
      trs_q <= trs_d;
      chroma_phase_q <= chroma_phase_d;
    end
  end

  // registered outputs
  logic seen_pixel_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pixel_o <= '0;
      pixel_valid_o <= 1'b0;
      chroma_phase_flag_o <= 1'b0;
      embedded_code_o <= 1'b0;
      timing_status_o <= '0;
      line_start_o <= 1'b0;
      format_error_o <= 1'b0;
      rgb_format_o <= 1'b0;
      pixel_index_o <= '0;
      seen_pixel_q <= 1'b0;
    end
    else
    begin
      pixel_valid_o <= take_second;
      embedded_code_o <= code_done;
      line_start_o <= sync_lead;
      format_error_o <= fmt_err;
      // only RGB formats are fit for the display path
      rgb_format_o <= !ycc_mode && !fmt_err;
      if (take_second)
      begin
        pixel_o <= pix_dec;
        chroma_phase_flag_o <= chroma_phase_q;
      end
      if (code_done)
      begin
        timing_status_o <= status_d;
      end
      if (sync_lead)
      begin
        seen_pixel_q <= 1'b0;
      end
      else if (take_second)
      begin
        seen_pixel_q <= 1'b1;
        pixel_index_o <= seen_pixel_q ? index_next : '0;
      end
    end
  end

endmodule : muxed_video_input_port

/* video_port_monitor.sv */
// assertions on the ports of the multiplexed video input port
`timescale 1ns/1ps
module video_port_monitor
  import muxed_video_input_port_pkg::*;
#(
  parameter int INDEX_WIDTH = 12
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic line_sync_i,
  input wire format_t input_format_select_i,
  input wire pixel_t pixel_o,
  input wire logic pixel_valid_o,
  input wire logic [INDEX_WIDTH-1:0] pixel_index_o,
  input wire logic line_start_o,
  input wire logic embedded_code_o,
  input wire timing_status_t timing_status_o,
  input wire logic format_error_o,
  input wire logic rgb_format_o
);
  logic sync_seen_q;
  logic [INDEX_WIDTH-1:0] last_index_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // remembers whether a line start came since the last pixel
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_seen_q <= 1'b1;
      last_index_q <= '0;
    end
    else
    begin
      sync_seen_q <= line_start_o | (sync_seen_q & ~pixel_valid_o);
      if (pixel_valid_o)
        last_index_q <= pixel_index_o;
    end
  end
  a_valid_one_cycle: assert property (pixel_valid_o |=> !pixel_valid_o) else $error("valid too long");
  a_sync_to_start: assert property ($rose(line_sync_i) |-> ##[2:6] line_start_o) else $error("no line start");
  a_index_step: assert property (pixel_valid_o |-> pixel_index_o == (sync_seen_q ? '0 : last_index_q + 1'b1))
    else $error("bad index");
  a_format_error: assert property (input_format_select_i > 3'h4 |=> format_error_o) else $error("no error flag");
  a_rgb_level: assert property (input_format_select_i < 3'h4 |=> rgb_format_o && !format_error_o)
    else $error("bad rgb flag");
  a_error_pixel_zero: assert property (pixel_valid_o && format_error_o |-> pixel_o == '0) else $error("bad pixel");
  a_ycc_low_zero: assert property (pixel_valid_o && input_format_select_i == 3'h4 |-> pixel_o.lo == 8'h00)
    else $error("low byte set");
  a_rgb565_fill: assert property (pixel_valid_o && input_format_select_i == 3'h2 |->
    pixel_o.hi[2:0] == 3'h0 && pixel_o.mid[1:0] == 2'h0 && pixel_o.lo[2:0] == 3'h0) else $error("fill");
  a_code_status: assert property (embedded_code_o |-> pixel_valid_o &&
    timing_status_o == {pixel_o.hi[6], pixel_o.hi[5], pixel_o.hi[4]}) else $error("bad status");
  c_pixel: cover property (pixel_valid_o);
  c_code: cover property (embedded_code_o);
  c_error: cover property (pixel_valid_o && format_error_o);
endmodule : video_port_monitor
bind muxed_video_input_port video_port_monitor #(.INDEX_WIDTH(INDEX_WIDTH)) u_mon (.core_clk_i, .rst_n_i,
  .line_sync_i, .input_format_select_i, .pixel_o, .pixel_valid_o, .pixel_index_o, .line_start_o,
  .embedded_code_o, .timing_status_o, .format_error_o, .rgb_format_o);

/* video_source_model.sv */
// graphics controller output port: link clock pair, word bus, line sync
`timescale 1ns/1ps
module video_source_model (
  input wire logic core_clk_i,
  input wire logic rate_2x_i,
  input wire logic polarity_i,
  input wire logic ycc_i,
  output logic clk_p_o,
  output logic clk_n_o,
  output logic [11:0] data_o,
  output logic sync_o
);
  assign clk_n_o = ~clk_p_o;
  initial
  begin
    clk_p_o = 1'b0;
    data_o = 12'h000;
    sync_o = 1'b0;
  end
  // one bus word; clock stands still between words
  task automatic word(input logic [11:0] w);
    @(posedge core_clk_i);
    data_o <= w;
    if (rate_2x_i)
      clk_p_o <= polarity_i;
    repeat (4) @(posedge core_clk_i);
    clk_p_o <= ~clk_p_o;
    repeat (4) @(posedge core_clk_i);
  endtask : word
  // line sync pulse with blank levels on the bus
  task automatic sync();
    @(posedge core_clk_i);
    data_o <= ycc_i ? 12'h080 : 12'h000;
    sync_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sync_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : sync
endmodule : video_source_model

/* tb_muxed_video_input_port.sv */
// testbench of the multiplexed video input port
`timescale 1ns/1ps
module tb_muxed_video_input_port;
  import muxed_video_input_port_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i;
  logic rate_2x;
  logic pol;
  logic se_clk;
  format_t fmt;
  logic clk_p, clk_n, sync_l;
  logic [11:0] data;
  pixel_t pix;
  logic valid, lstart, chroma, code, ferr, rgb;
  logic [11:0] index;
  timing_status_t status;
  logic [23:0] pq[$];
  logic [11:0] iq[$];
  logic cq[$];
  logic [2:0] sq;
  int codes, miscompares, checked;
  always #50 core_clk_i = ~core_clk_i;
  video_source_model src (.core_clk_i(core_clk_i), .rate_2x_i(rate_2x), .polarity_i(pol), .ycc_i(fmt == 3'h4),
    .clk_p_o(clk_p), .clk_n_o(clk_n), .data_o(data), .sync_o(sync_l));
  muxed_video_input_port DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .pixel_clock_pair_p_i(clk_p),
    .pixel_clock_pair_n_i(clk_n), .data_i(data), .line_sync_i(sync_l), .clock_rate_2x_i(rate_2x),
    .capture_edge_polarity_i(pol), .single_ended_clock_i(se_clk), .input_format_select_i(fmt), .pixel_o(pix),
    .pixel_valid_o(valid), .pixel_index_o(index), .line_start_o(lstart), .chroma_phase_flag_o(chroma),
    .embedded_code_o(code), .timing_status_o(status), .format_error_o(ferr), .rgb_format_o(rgb));
  always @(posedge core_clk_i)
  begin
    if (valid)
    begin
      pq.push_back(pix);
      iq.push_back(index);
      cq.push_back(chroma);
    end
    if (code)
    begin
      sq = status;
      codes++;
    end
  end
  task automatic finish_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [23:0] expect_px(input format_t f, input logic [11:0] a, input logic [11:0] b);
    case (f)
      3'h0: return {b, a};
      3'h1: return {b[11:7], b[3:1], b[6:4], a[11:9], b[0], a[3], a[8:4], a[2:0]};
      3'h2: return {b[11:7], 3'h0, b[6:4], a[11:9], 2'h0, a[8:4], 3'h0};
      3'h3: return {b[10:6], 3'h0, b[5:4], a[11:9], 3'h0, a[8:4], 3'h0};
      3'h4: return {b[7:0], a[7:0], 8'h00};
      default: return 24'h000000;
    endcase
  endfunction : expect_px
  // sync, then empty the collected pixels
  task automatic start_line();
    src.sync();
    pq.delete();
    iq.delete();
    cq.delete();
    codes = 0;
  endtask : start_line
  task automatic wait_px(input int n);
    for (int i = 0; i < 80 && pq.size() < n; i++)
      @(posedge core_clk_i);
    if (pq.size() < n)
    begin
      miscompares++;
      finish_test();
    end
  endtask : wait_px
  // every format, with a stray word before sync
  task automatic test_formats();
    for (int f = 0; f < 6; f++)
    begin
      @(posedge core_clk_i);
      fmt <= format_t'(f);
      src.word(12'hA5C);
      start_line();
      src.word(12'h9B6);
      src.word(12'h5E3);
      wait_px(1);
      chk(pq[0], expect_px(fmt, 12'h9B6, 12'h5E3));
      chk(iq[0], 24'h0);
      chk({ferr, rgb}, {22'h0, f > 4, f < 4});
    end
  endtask : test_formats
  // clock at pixel rate, both edges capture
  task automatic test_dual_edge();
    @(posedge core_clk_i);
    rate_2x <= 1'b0;
    fmt <= 3'h0;
    start_line();
    for (int i = 0; i < 6; i++)
      src.word(12'h111 * (i + 1));
    wait_px(3);
    chk(pq[2], expect_px(3'h0, 12'h555, 12'h666));
    chk(iq[2], 24'h2);
  endtask : test_dual_edge
  // falling edge only at double rate
  task automatic test_falling();
    @(posedge core_clk_i);
    rate_2x <= 1'b1;
    pol <= 1'b1;
    start_line();
    src.word(12'h3C1);
    src.word(12'hC3E);
    repeat (12) @(posedge core_clk_i);
    chk(pq.size(), 24'h1);
    chk(pq[0], expect_px(3'h0, 12'h3C1, 12'hC3E));
  endtask : test_falling
  // luma/chroma order, then an embedded code
  task automatic test_ycc();
    @(posedge core_clk_i);
    pol <= 1'b0;
    fmt <= 3'h4;
    start_line();
    src.word(12'h040);
    src.word(12'h051);
    src.word(12'h062);
    src.word(12'h073);
    src.word(12'h0FF);
    src.word(12'h000);
    src.word(12'h000);
    src.word(12'h070);
    wait_px(4);
    chk({cq[0], cq[1]}, 24'h1);
    chk(pq[1], 24'h736200);
    chk({codes[7:0], sq}, {8'h1, 3'h7});
  endtask : test_ycc
  // single-ended clock mode, 565 pair; the model still drives the complementary line as ~clk_p_o
  task automatic test_single_ended();
    @(posedge core_clk_i);
    se_clk <= 1'b1;
    fmt <= 3'h2;
    start_line();
    src.word(12'hE71);
    src.word(12'h8C9);
    wait_px(1);
    chk(pq[0], expect_px(3'h2, 12'hE71, 12'h8C9));
    chk(iq[0], 24'h0);
  endtask : test_single_ended
  initial
  begin
    rst_n_i <= 1'b0;
    rate_2x <= 1'b1;
    pol <= 1'b0;
    se_clk <= 1'b0;
    fmt <= 3'h0;
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    test_formats();
    test_dual_edge();
    test_falling();
    test_ycc();
    test_single_ended();
    finish_test();
  end
endmodule : tb_muxed_video_input_port
